// ---- ptl_bcd_counter.sv ----
// decimal total and grand total counters
`timescale 1ns/1ps
`default_nettype none
`include "ptl_cfg.svh"
module ptl_bcd_counter
    import ptl_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    ptl_cnt_if.cnt c
);
    localparam int TD = `PTL_TOT_DIGITS;
    localparam int GD = `PTL_GT_DIGITS;
    ptl_tot_t tot;
    ptl_gt_t gt;
    ptl_tot_t next_tot;
    ptl_gt_t next_gt;
    logic [TD:0] tcy;
    logic [GD:0] gcy;
    ptl_tot_t tinc;
    ptl_gt_t ginc;

    assign tcy[0] = 1'b1;
    assign gcy[0] = 1'b1;
    genvar i;
    generate
        for (i = 0; i < GD; i++)
        begin : g_gd
            assign ginc[i*4 +: 4] = gcy[i] ? ((gt[i*4 +: 4] == 4'h9) ? 4'h0
                : gt[i*4 +: 4] + 4'h1) : gt[i*4 +: 4];
            assign gcy[i+1] = gcy[i] && (gt[i*4 +: 4] == 4'h9);
            if (i < TD)
            begin : g_td
                assign tinc[i*4 +: 4] = tcy[i] ? ((tot[i*4 +: 4] == 4'h9) ? 4'h0
                    : tot[i*4 +: 4] + 4'h1) : tot[i*4 +: 4];
                assign tcy[i+1] = tcy[i] && (tot[i*4 +: 4] == 4'h9);
            end
        end
    endgenerate

    always_comb
    begin
        next_tot = tot;
        next_gt = gt;
        if (c.load)
        begin
            next_tot = c.tot_load;
            next_gt = c.gt_load;
        end
        else
        begin
            if (c.inc)
            begin
                next_tot = tinc;
                next_gt = ginc;
            end
            // a clear in the same cycle as a pulse wins for the counter it clears; the other counter still takes the pulse
            if (c.clr_tot)
                next_tot = '0;
            if (c.clr_gt)
                next_gt = '0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tot <= '0;
            gt <= '0;
        end
        else
        begin
            tot <= next_tot;
            gt <= next_gt;
        end
    end

    assign c.tot = tot;
    assign c.gt = gt;
endmodule : ptl_bcd_counter
`default_nettype wire

// ---- ptl_cfg.svh ----
// timing, width and code constants for the totaliser panel logic
`ifndef PTL_CFG_SVH
`define PTL_CFG_SVH
`define PTL_CLK_MHZ 125
`define PTL_STARTUP_MS 100
`define PTL_STARTUP_CYC (`PTL_STARTUP_MS * 1000 * `PTL_CLK_MHZ)
`define PTL_TEST_MS 1000
`define PTL_TEST_CYC (`PTL_TEST_MS * 1000 * `PTL_CLK_MHZ)
`define PTL_GT_HOLD_S 10
`define PTL_GT_HOLD_CYC (`PTL_GT_HOLD_S * 1000000 * `PTL_CLK_MHZ)
`define PTL_T_HOLD_S 3
`define PTL_T_HOLD_CYC (`PTL_T_HOLD_S * 1000000 * `PTL_CLK_MHZ)
`define PTL_FLOW_S 2
`define PTL_FLOW_CYC (`PTL_FLOW_S * 1000000 * `PTL_CLK_MHZ)
`define PTL_MSG_MS 1500
`define PTL_MSG_CYC (`PTL_MSG_MS * 1000 * `PTL_CLK_MHZ)
`define PTL_TOT_DIGITS 8
`define PTL_GT_DIGITS 16
`define PTL_RATE_DIGITS 6
`define PTL_LIN_SEGMENTS 16
`define PTL_CODE_DIGITS 4
`define PTL_MSG_NONE 4'h0
`define PTL_MSG_LO 4'h1
`define PTL_MSG_HI 4'h2
`define PTL_MSG_CLR_NO 4'h3
`define PTL_MSG_CLR_YES 4'h4
`define PTL_MSG_CLEARED 4'h5
`define PTL_MSG_VERSION 4'h6
`define PTL_MSG_FUNCTION 4'h7
`define PTL_MSG_ACC_ALARM 4'h8
`define PTL_MSG_ACC_PULSE 4'h9
`define PTL_MSG_ACC_LOOP 4'hA
`define PTL_MSG_ALL_ON 4'hB
`define PTL_MSG_CODE 4'hC
`endif

// ---- ptl_cnt_if.sv ----
// carrier between panel top and bcd counter
`timescale 1ns/1ps
`default_nettype none
`include "ptl_cfg.svh"
interface ptl_cnt_if;
    logic inc;
    logic clr_tot;
    logic clr_gt;
    logic [`PTL_TOT_DIGITS*4-1:0] tot;
    logic [`PTL_GT_DIGITS*4-1:0] gt;
    logic [`PTL_TOT_DIGITS*4-1:0] tot_load;
    logic [`PTL_GT_DIGITS*4-1:0] gt_load;
    logic load;
    modport ctl (output inc, output clr_tot, output clr_gt, output tot_load, output gt_load,
        output load, input tot, input gt);
    modport cnt (input inc, input clr_tot, input clr_gt, input tot_load, input gt_load,
        input load, output tot, output gt);
endinterface : ptl_cnt_if
`default_nettype wire

// ---- ptl_flow_model.sv ----
// flowmeter pulse source for the panel bench
`timescale 1ns/1ps
`default_nettype none
module ptl_flow_model (
    input wire logic core_clk,
    input wire logic fire,
    output logic pulse_in
);
    int cnt = 0;
    // pulse held several cycles so the input synchroniser sees it
    always @(posedge core_clk)
    begin
        if (fire)
            cnt <= 4;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
    assign pulse_in = (cnt > 0);
endmodule : ptl_flow_model
`default_nettype wire

// ---- ptl_hold_timer.sv ----
// button-pair hold timer, cancelled on release
`timescale 1ns/1ps
`default_nettype none
module ptl_hold_timer #(
    parameter int unsigned LIMIT = 10
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic held,
    output logic fire
);
    logic [31:0] cnt;
    logic done;
    logic [31:0] next_cnt;
    logic next_done;
    logic next_fire;

    always_comb
    begin
        next_cnt = cnt;
        next_done = done;
        next_fire = 1'b0;
        if (!held)
        begin
            next_cnt = '0;
            next_done = 1'b0;
        end
        else if (!done)
        begin
            if (cnt >= LIMIT - 1)
            begin
                next_fire = 1'b1;
                next_done = 1'b1;
            end
            else
                next_cnt = cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt <= '0;
            done <= 1'b0;
            fire <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            done <= next_done;
            fire <= next_fire;
        end
    end
endmodule : ptl_hold_timer
`default_nettype wire

// ---- ptl_panel.sv ----
// pulse totaliser panel logic: counting, buttons, display selection, annunciators
`timescale 1ns/1ps
`default_nettype none
`include "ptl_cfg.svh"
// Behaviour
// - keep sixteen-digit grand total; low request shows low marker then low eight digits
// - high request shows high marker then upper eight grand-total digits
// - reset pair held ten seconds with grand clear enabled prompts, answer no
// - up or down turns answer yes; confirm zeroes grand total, shows cleared
// - reset pair held three seconds with total clear enabled zeroes total, drops stored pulses
// - total reset leaves grand total untouched
// - after power-up delay, light all segments, then run stored configuration
// - totals come back from storage at power-up and keep accumulating
// - total shown on upper eight digits, clearable by panel or remote input
// - rate shown on lower six digits
// - each pulse animates flow indicator two seconds, retriggerable
// - hold annunciator on while input frequency below clip-off threshold
// - reset annunciator on while any reset is in progress
// - lineariser supports up to sixteen segments
// - information request shows version, function, then fitted accessory codes, pulse always
// - menu button pair in totalising mode enters configuration menu
// - setpoint pair opens setpoints only with alarms fitted and access enabled
// - menu entry needs the four-digit security code when one is set
// - overflowing grand total or rate shows all nines with decimal points flashing; the total wraps
// - remote reset contact zeroes total; held closed it inhibits counting
module ptl_panel
    import ptl_pkg::*;
#(
    parameter int unsigned STARTUP_CYC = `PTL_STARTUP_CYC,
    parameter int unsigned TEST_CYC = `PTL_TEST_CYC,
    parameter int unsigned GT_HOLD_CYC = `PTL_GT_HOLD_CYC,
    parameter int unsigned T_HOLD_CYC = `PTL_T_HOLD_CYC,
    parameter int unsigned FLOW_CYC = `PTL_FLOW_CYC,
    parameter int unsigned MSG_CYC = `PTL_MSG_CYC
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic pulse_in,
    input wire logic remote_reset_in,
    input wire logic btn_menu,
    input wire logic btn_down,
    input wire logic btn_up,
    input wire logic btn_enter,
    input wire logic panel_total_clear_enable,
    input wire logic panel_grand_total_clear_enable,
    input wire logic setpoint_direct_access_enable,
    input wire logic alarms_fitted,
    input wire logic loop_output_fitted,
    input wire logic code_set,
    input wire logic code_ok,
    input wire logic menu_exit,
    input wire logic below_clip_off,
    input wire ptl_pkg::ptl_rate_t rate_value,
    input wire logic rate_overrange,
    input wire logic [3:0] lin_segments,
    input wire ptl_pkg::ptl_tot_t stored_total,
    input wire ptl_pkg::ptl_gt_t stored_grand_total,
    input wire logic [7:0] firmware_version,
    output logic [`PTL_TOT_DIGITS*4-1:0] upper_digits,
    output logic [`PTL_RATE_DIGITS*4-1:0] lower_digits,
    output logic [3:0] message_code,
    output logic all_segments_on,
    output logic dp_flash,
    output logic flow_indicator,
    output logic hold_annunciator,
    output logic reset_annunciator,
    output logic stored_pulse_clear,
    output logic in_config_menu,
    output logic in_setpoint_adjust,
    output logic [3:0] lin_segment_count,
    output logic [`PTL_GT_DIGITS*4-1:0] grand_total
);
    localparam int TD = `PTL_TOT_DIGITS;
    localparam logic [3:0] LIN_MAX = 4'(`PTL_LIN_SEGMENTS - 1);

    logic rst_a, rst_n;
    logic [1:0] pin_s1, pin_s2;
    logic pulse_prev, pulse_edge, remote_prev;
    logic fire_t, fire_gt;
    logic pair_reset;
    logic [3:0] btn_prev;
    logic [3:0] btn_rise;
    ptl_state_t state, next_state;
    logic [31:0] tmr, next_tmr;
    logic [31:0] flow_tmr, next_flow_tmr;
    ptl_msg_t msg, next_msg;
    logic sel_hi, next_sel_hi;
    logic info_step, next_info_step;
    logic gt_ovf, next_gt_ovf;
    ptl_tot_t next_upper;
    logic next_clr_gt, next_clr_tot;
    ptl_cnt_if cif ();

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_a <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_a <= 1'b1;
            rst_n <= rst_a;
        end
    end

    // pulse and remote pins pass two flops before anything looks at them; buttons are used unsynchronised
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pulse_prev <= 1'b0;
            remote_prev <= 1'b0;
            btn_prev <= '0;
        end
        else
        begin
            pin_s1 <= {remote_reset_in, pulse_in};
            pin_s2 <= pin_s1;
            pulse_prev <= pin_s2[0];
            remote_prev <= pin_s2[1];
            btn_prev <= {btn_menu, btn_down, btn_up, btn_enter};
        end
    end
    assign pulse_edge = pin_s2[0] && !pulse_prev;
    assign btn_rise = {btn_menu, btn_down, btn_up, btn_enter} & ~btn_prev;
    assign pair_reset = btn_up && btn_down && !btn_menu && !btn_enter;

    ptl_hold_timer #(.LIMIT(T_HOLD_CYC)) u_hold_t (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .held(pair_reset && panel_total_clear_enable && state == PTL_RUN),
        .fire(fire_t)
    );
    ptl_hold_timer #(.LIMIT(GT_HOLD_CYC)) u_hold_gt (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .held(pair_reset && panel_grand_total_clear_enable && state == PTL_RUN),
        .fire(fire_gt)
    );
    ptl_bcd_counter u_cnt (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .c(cif)
    );

    // counting held off while the remote contact stays closed
    assign cif.inc = pulse_edge && !pin_s2[1] && (state != PTL_BOOT) && (state != PTL_TEST);
    assign cif.clr_tot = next_clr_tot;
    assign cif.clr_gt = next_clr_gt;
    assign cif.tot_load = stored_total;
    assign cif.gt_load = stored_grand_total;
    // last boot cycle: the boot timer hands over to the test phase before reaching zero
    assign cif.load = (state == PTL_BOOT) && (tmr == 32'h0000_0001);

    always_comb
    begin
        next_state = state;
        next_tmr = (tmr != 32'h0000_0000) ? tmr - 32'h0000_0001 : tmr;
        next_msg = msg;
        next_sel_hi = sel_hi;
        next_info_step = info_step;
        next_clr_gt = 1'b0;
        next_clr_tot = 1'b0;
        if (pin_s2[1] && !remote_prev)
            next_clr_tot = 1'b1;
        if (fire_t)
            next_clr_tot = 1'b1;
        case (state)
            PTL_BOOT:
            begin
                if (tmr == 32'h0000_0001)
                begin
                    next_state = PTL_TEST;
                    next_tmr = TEST_CYC;
                    next_msg = `PTL_MSG_ALL_ON;
                end
            end
            PTL_TEST:
            begin
                if (tmr == 32'h0000_0001)
                begin
                    next_state = PTL_RUN;
                    next_msg = `PTL_MSG_NONE;
                end
            end
            PTL_RUN:
            begin
                if (fire_gt)
                begin
                    next_state = PTL_ASK;
                    next_msg = `PTL_MSG_CLR_NO;
                end
                else if (btn_menu && btn_enter && btn_rise != 4'h0)
                begin
                    next_state = PTL_MENU;
                    next_msg = code_set ? `PTL_MSG_CODE : `PTL_MSG_NONE;
                end
                else if (btn_menu && btn_up && btn_rise != 4'h0)
                begin
                    if (alarms_fitted && setpoint_direct_access_enable)
                        next_state = PTL_SETP;
                end
                else if (btn_rise[2] && btn_enter)
                begin
                    next_state = PTL_SHOW;
                    next_msg = `PTL_MSG_LO;
                    next_sel_hi = 1'b0;
                    next_tmr = MSG_CYC;
                end
                else if (btn_rise[1] && btn_enter)
                begin
                    next_state = PTL_SHOW;
                    next_msg = `PTL_MSG_HI;
                    next_sel_hi = 1'b1;
                    next_tmr = MSG_CYC;
                end
                else if (btn_rise[0] && !btn_menu && !btn_up && !btn_down)
                begin
                    next_state = PTL_SHOW;
                    next_msg = `PTL_MSG_VERSION;
                    next_info_step = 1'b1;
                    next_tmr = MSG_CYC;
                end
            end
            PTL_SHOW:
            begin
                if (tmr == 32'h0000_0001)
                begin
                    next_tmr = MSG_CYC;
                    case (msg)
                        `PTL_MSG_LO, `PTL_MSG_HI: next_msg = `PTL_MSG_NONE;
                        `PTL_MSG_VERSION: next_msg = `PTL_MSG_FUNCTION;
                        `PTL_MSG_FUNCTION:
                            next_msg = alarms_fitted ? `PTL_MSG_ACC_ALARM : `PTL_MSG_ACC_PULSE;
                        `PTL_MSG_ACC_ALARM: next_msg = `PTL_MSG_ACC_PULSE;
                        `PTL_MSG_ACC_PULSE:
                            next_msg = loop_output_fitted ? `PTL_MSG_ACC_LOOP : `PTL_MSG_NONE;
                        default: next_msg = `PTL_MSG_NONE;
                    endcase
                    // a blank phase closes every sequence; the digits stay up through it
                    if (msg == `PTL_MSG_NONE)
                    begin
                        next_state = PTL_RUN;
                        next_tmr = 32'h0000_0000;
                        next_info_step = 1'b0;
                    end
                end
            end
            PTL_ASK:
            begin
                if ((btn_rise[1] || btn_rise[2]) && msg == `PTL_MSG_CLR_NO)
                    next_msg = `PTL_MSG_CLR_YES;
                else if (btn_rise[0] && msg == `PTL_MSG_CLR_YES)
                begin
                    next_clr_gt = 1'b1;
                    next_state = PTL_DONE;
                    next_msg = `PTL_MSG_CLEARED;
                    next_tmr = MSG_CYC;
                end
                else if (btn_rise[0])
                begin
                    next_state = PTL_RUN;
                    next_msg = `PTL_MSG_NONE;
                end
            end
            PTL_DONE:
            begin
                if (tmr == 32'h0000_0000)
                begin
                    next_state = PTL_RUN;
                    next_msg = `PTL_MSG_NONE;
                end
            end
            PTL_MENU:
            begin
                if (code_set && msg == `PTL_MSG_CODE && code_ok)
                    next_msg = `PTL_MSG_NONE;
                if (menu_exit)
                begin
                    next_state = PTL_RUN;
                    next_msg = `PTL_MSG_NONE;
                end
            end
            PTL_SETP:
            begin
                if (menu_exit)
                    next_state = PTL_RUN;
            end
            default:
            begin
                next_state = PTL_BOOT;
                next_tmr = STARTUP_CYC;
            end
        endcase
    end

    always_comb
    begin
        next_flow_tmr = (flow_tmr != 32'h0000_0000) ? flow_tmr - 32'h0000_0001 : flow_tmr;
        if (pulse_edge)
            next_flow_tmr = FLOW_CYC;
        next_gt_ovf = gt_ovf;
        if (cif.inc && (&(cif.gt == {`PTL_GT_DIGITS{4'h9}})))
            next_gt_ovf = 1'b1;
        if (next_clr_gt)
            next_gt_ovf = 1'b0;
        if (state == PTL_SHOW && sel_hi)
            next_upper = cif.gt[TD*4 +: TD*4];
        else if (state == PTL_SHOW && !info_step)
            next_upper = cif.gt[TD*4-1:0];
        else
            next_upper = cif.tot;
        if (gt_ovf && state == PTL_SHOW && !info_step)
            next_upper = {TD{4'h9}};
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= PTL_BOOT;
            tmr <= STARTUP_CYC;
            flow_tmr <= '0;
            msg <= `PTL_MSG_NONE;
            sel_hi <= 1'b0;
            info_step <= 1'b0;
            gt_ovf <= 1'b0;
            upper_digits <= '0;
            lower_digits <= '0;
            message_code <= '0;
            all_segments_on <= 1'b0;
            dp_flash <= 1'b0;
            flow_indicator <= 1'b0;
            hold_annunciator <= 1'b0;
            reset_annunciator <= 1'b0;
            stored_pulse_clear <= 1'b0;
            in_config_menu <= 1'b0;
            in_setpoint_adjust <= 1'b0;
            lin_segment_count <= '0;
            grand_total <= '0;
        end
        else
        begin
            state <= next_state;
            tmr <= next_tmr;
            flow_tmr <= next_flow_tmr;
            msg <= next_msg;
            sel_hi <= next_sel_hi;
            info_step <= next_info_step;
            gt_ovf <= next_gt_ovf;
            upper_digits <= next_upper;
            lower_digits <= rate_overrange ? {`PTL_RATE_DIGITS{4'h9}} : rate_value;
            message_code <= next_msg;
            all_segments_on <= (next_state == PTL_TEST);
            dp_flash <= rate_overrange || (gt_ovf && state == PTL_SHOW);
            flow_indicator <= (next_flow_tmr != 32'h0000_0000);
            hold_annunciator <= below_clip_off;
            reset_annunciator <= pin_s2[1] || (pair_reset && state == PTL_RUN &&
                (panel_total_clear_enable || panel_grand_total_clear_enable)) ||
                next_state == PTL_ASK || next_state == PTL_DONE;
            stored_pulse_clear <= fire_t;
            in_config_menu <= (next_state == PTL_MENU) && !(code_set && next_msg == `PTL_MSG_CODE);
            in_setpoint_adjust <= (next_state == PTL_SETP);
            lin_segment_count <= (lin_segments > LIN_MAX) ? LIN_MAX : lin_segments;
            grand_total <= cif.gt;
        end
    end

    flow_retrig_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        pulse_edge |=> ##1 flow_indicator)
        else $error("flow indicator not lit after pulse");
    gt_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (fire_t && !next_clr_gt && !cif.inc && !cif.load) |=> $stable(cif.gt))
        else $error("grand total moved on total reset");
    tot_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        fire_t |=> (cif.tot == '0) && stored_pulse_clear)
        else $error("total not cleared on hold");
    ask_no_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == PTL_RUN && fire_gt) |=> (state == PTL_ASK && msg == `PTL_MSG_CLR_NO))
        else $error("grand total prompt missing");
    gt_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == PTL_ASK && msg == `PTL_MSG_CLR_YES && btn_rise[0] && !cif.load)
        |=> (cif.gt == '0) && state == PTL_DONE)
        else $error("grand total not cleared on confirm");
    remote_inh_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        pin_s2[1] |-> !cif.inc)
        else $error("counting while remote reset closed");
    hold_ann_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        below_clip_off |=> hold_annunciator)
        else $error("hold annunciator off below clip-off");
    setp_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state != PTL_SETP && next_state == PTL_SETP) |-> (alarms_fitted &&
        setpoint_direct_access_enable))
        else $error("setpoint access without permission");
endmodule : ptl_panel
`default_nettype wire

// ---- ptl_pkg.sv ----
// types shared by the totaliser panel logic
`default_nettype none
`include "ptl_cfg.svh"
package ptl_pkg;
    typedef logic [`PTL_TOT_DIGITS*4-1:0] ptl_tot_t;
    typedef logic [`PTL_GT_DIGITS*4-1:0] ptl_gt_t;
    typedef logic [`PTL_RATE_DIGITS*4-1:0] ptl_rate_t;
    typedef logic [3:0] ptl_msg_t;
    typedef enum logic [7:0] {
        PTL_BOOT = 8'h01,
        PTL_TEST = 8'h02,
        PTL_RUN = 8'h04,
        PTL_SHOW = 8'h08,
        PTL_ASK = 8'h10,
        PTL_DONE = 8'h20,
        PTL_MENU = 8'h40,
        PTL_SETP = 8'h80
    } ptl_state_t;
endpackage : ptl_pkg
`default_nettype wire

// ---- pulse_totaliser_panel_logic_test.sv ----
// self-checking bench for the totaliser panel logic
`timescale 1ns/1ps
`default_nettype none
`include "ptl_cfg.svh"
module pulse_totaliser_panel_logic_test;
    import ptl_pkg::*;
    logic core_clk = 0, rstn = 0, fire = 0, pulse_in, remote_reset_in = 0, rate_overrange;
    logic panel_total_clear_enable = 1, panel_grand_total_clear_enable = 1, menu_exit = 0;
    logic setpoint_direct_access_enable = 0, alarms_fitted, loop_output_fitted, code_set = 0;
    logic code_ok = 0, below_clip_off = 1, all_segments_on, dp_flash, flow_indicator;
    logic hold_annunciator, reset_annunciator, stored_pulse_clear, in_config_menu;
    logic in_setpoint_adjust;
    logic [3:0] btn = 4'h0, lin_segments, message_code, lin_segment_count;
    logic [7:0] firmware_version;
    ptl_rate_t rate_value, lower_digits;
    ptl_tot_t stored_total = 32'h0000_0010, upper_digits;
    ptl_gt_t stored_grand_total = 64'h0000_1234_0000_5678, grand_total;
    int errors = 0, comparisons = 0, seed = 99411, n;
    int pulse_clears = 0;
    ptl_gt_t gt_exp;

    always #4 core_clk = ~core_clk;

    always @(posedge core_clk)
        if (stored_pulse_clear === 1'b1)
            pulse_clears++;

    ptl_flow_model ptl_flow_model_inst (.core_clk(core_clk), .fire(fire), .pulse_in(pulse_in));
    ptl_panel #(.STARTUP_CYC(20), .TEST_CYC(20), .GT_HOLD_CYC(200), .T_HOLD_CYC(60),
        .FLOW_CYC(50), .MSG_CYC(30)) ptl_panel_inst (.*, .btn_menu(btn[3]), .btn_down(btn[2]),
        .btn_up(btn[1]), .btn_enter(btn[0]));

    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
    endtask : cyc

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // partner button held first, hold time counts from the second press
    task automatic combo(input logic [3:0] a, input logic [3:0] b, input int hold);
        btn <= a;
        cyc(2);
        btn <= a | b;
        cyc(hold);
        btn <= 4'h0;
        cyc(2);
    endtask : combo

    task automatic pulses(input int k);
        repeat (k)
        begin
            fire <= 1;
            cyc(1);
            fire <= 0;
            cyc(9);
        end
    endtask : pulses

    // decimal add of a small count, one digit carry at a time
    function automatic ptl_gt_t exp_bcd(input ptl_gt_t base, input int k);
        ptl_gt_t v;
        v = base;
        repeat (k)
        begin
            for (int d = 0; d < `PTL_GT_DIGITS; d++)
            begin
                if (v[d*4 +: 4] != 4'h9)
                begin
                    v[d*4 +: 4] = v[d*4 +: 4] + 4'h1;
                    break;
                end
                v[d*4 +: 4] = 4'h0;
            end
        end
        return v;
    endfunction : exp_bcd

    task automatic wrap_up();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    initial
    begin
        repeat (5000) @(posedge core_clk);
        errors++;
        wrap_up();
    end

    initial
    begin
        rate_value <= {20'h9_8765, 4'($unsigned($random(seed)) % 10)};
        lin_segments <= 4'($random(seed));
        {alarms_fitted, loop_output_fitted, rate_overrange} <= 3'($random(seed));
        firmware_version <= 8'($random(seed));
        n = 1 + $unsigned($random(seed)) % 8;
        cyc(3);
        rstn <= 1;
        cyc(27);
        chk(all_segments_on, 1);
        cyc(25);
        chk(all_segments_on, 0);
        chk(grand_total, stored_grand_total);
        chk(upper_digits, stored_total);
        chk(lower_digits, rate_overrange ? 24'h99_9999 : rate_value);
        chk(dp_flash, rate_overrange);
        chk(hold_annunciator, 1);
        chk(lin_segment_count, lin_segments);
        pulses(n);
        gt_exp = exp_bcd(stored_grand_total, n);
        chk(flow_indicator, 1);
        chk(upper_digits, exp_bcd(stored_total, n));
        cyc(60);
        chk(flow_indicator, 0);
        // pressed together: enter alone first is taken as the info request
        combo(4'b0000, 4'b0101, 3);
        chk(message_code, `PTL_MSG_LO);
        chk(upper_digits, gt_exp[31:0]);
        cyc(60);
        combo(4'b0000, 4'b0011, 3);
        chk(message_code, `PTL_MSG_HI);
        chk(upper_digits, gt_exp[63:32]);
        cyc(60);
        combo(4'b0000, 4'b0001, 3);
        chk(message_code, `PTL_MSG_VERSION);
        cyc(30);
        chk(message_code, `PTL_MSG_FUNCTION);
        cyc(30);
        chk(message_code, alarms_fitted ? `PTL_MSG_ACC_ALARM : `PTL_MSG_ACC_PULSE);
        cyc(125);
        below_clip_off <= 0;
        combo(4'b0100, 4'b0010, 30);
        chk(upper_digits, exp_bcd(stored_total, n));
        combo(4'b0100, 4'b0010, 70);
        chk(upper_digits, 0);
        chk(grand_total, gt_exp);
        chk(hold_annunciator, 0);
        chk(pulse_clears, 1);
        pulses(2);
        remote_reset_in <= 1;
        cyc(5);
        chk(reset_annunciator, 1);
        chk(upper_digits, 0);
        pulses(1);
        chk(upper_digits, 0);
        remote_reset_in <= 0;
        cyc(5);
        chk(reset_annunciator, 0);
        combo(4'b1000, 4'b0001, 3);
        chk(in_config_menu, 1);
        menu_exit <= 1;
        cyc(3);
        menu_exit <= 0;
        code_set <= 1;
        setpoint_direct_access_enable <= 1;
        combo(4'b1000, 4'b0001, 3);
        chk(in_config_menu, 0);
        code_ok <= 1;
        cyc(2);
        chk(in_config_menu, 1);
        menu_exit <= 1;
        cyc(3);
        menu_exit <= 0;
        combo(4'b1000, 4'b0010, 3);
        chk(in_setpoint_adjust, alarms_fitted);
        menu_exit <= 1;
        cyc(3);
        menu_exit <= 0;
        combo(4'b0100, 4'b0010, 210);
        chk(message_code, `PTL_MSG_CLR_NO);
        combo(4'b0000, 4'b0010, 2);
        chk(message_code, `PTL_MSG_CLR_YES);
        combo(4'b0000, 4'b0001, 2);
        chk(message_code, `PTL_MSG_CLEARED);
        chk(grand_total, 0);
        wrap_up();
    end
endmodule : pulse_totaliser_panel_logic_test
`default_nettype wire
